/* pbp_params.svh */
// constants of the port b pad control and pin interrupt block
`ifndef PBP_PARAMS_SVH
`define PBP_PARAMS_SVH

// -------------------------------------------------------------------
// sizes
// -------------------------------------------------------------------
`define PBP_PINS      8
`define PBP_IRQ_PINS  4
`define PBP_ADDR_W    12

// -------------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------------
`define PBP_OFF_DIR      12'h000
`define PBP_OFF_PULL     12'h004
`define PBP_OFF_SLEW     12'h008
`define PBP_OFF_DRIVE    12'h00c
`define PBP_OFF_SC       12'h010
`define PBP_OFF_PSEL     12'h014
`define PBP_OFF_POL      12'h018
`define PBP_OFF_EVT_ST   12'h01c
`define PBP_OFF_EVT_MASK 12'h020

// -------------------------------------------------------------------
// status and control field positions
// -------------------------------------------------------------------
`define PBP_SC_MODE   0
`define PBP_SC_IE     1
`define PBP_SC_ACK    2
`define PBP_SC_FLAG   3

// event status bits: detection seen, detection in the same cycle as an acknowledge
`define PBP_EVT_DET   0
`define PBP_EVT_HELD  1
`define PBP_EVT_W     2

`endif

/* pbp_pkg.sv */
// types of the port b pad control and pin interrupt block
`include "pbp_params.svh"

package pbp_pkg;

  // -----------------------------------------------------------------
  // state of the top module
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [`PBP_PINS-1:0]     dir;
    logic [`PBP_PINS-1:0]     pull;
    logic [`PBP_PINS-1:0]     slew;
    logic [`PBP_PINS-1:0]     drive;
    logic                     mode;
    logic                     ie;
    logic                     flag;
    logic [`PBP_IRQ_PINS-1:0] sel;
    logic [`PBP_IRQ_PINS-1:0] pol;
    logic [`PBP_EVT_W-1:0]    evt_st;
    logic [`PBP_EVT_W-1:0]    evt_mask;
    logic [`PBP_PINS-1:0]     pad_drv_n;
    logic [`PBP_PINS-1:0]     pad_pull_en;
    logic [`PBP_PINS-1:0]     pad_pull_dn;
    logic [`PBP_PINS-1:0]     pad_slew;
    logic [`PBP_PINS-1:0]     pad_drive_hi;
    logic                     port_irq;
    logic                     irq;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } pbp_top_st_t;

  // -----------------------------------------------------------------
  // state of the pin detector
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [`PBP_IRQ_PINS-1:0] act_prev;
  } pbp_det_st_t;

endpackage

/* pbp_det_if.sv */
// signals between the register block and the pin detector
`timescale 1ns/1ps
`include "pbp_params.svh"

interface pbp_det_if;
  logic [`PBP_IRQ_PINS-1:0] sel;
  logic [`PBP_IRQ_PINS-1:0] pol;
  logic [`PBP_IRQ_PINS-1:0] pins;
  logic                     edge_hit;
  logic                     level_hit;

  modport ctl (output sel, output pol, output pins,
               input edge_hit, input level_hit);
  modport det (input sel, input pol, input pins,
               output edge_hit, output level_hit);
endinterface

/* pbp_pin_detect.sv */
// edge and level detector for the four interrupt pins
`timescale 1ns/1ps
`include "pbp_params.svh"

module pbp_pin_detect (
  input wire logic pclk,
  input wire logic presetn,
  pbp_det_if.det   dif
);

  pbp_pkg::pbp_det_st_t     s_ff;
  pbp_pkg::pbp_det_st_t     nxt_s;
  logic [`PBP_IRQ_PINS-1:0] act;

  // -----------------------------------------------------------------
  // per pin active level
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PBP_IRQ_PINS; gi++) begin : g_pin
      // unselected pins never count; polarity picks high or low
      assign act[gi] = dif.sel[gi] & ~(dif.pins[gi] ^ dif.pol[gi]);
    end
  endgenerate

  // edge: active now, not active last cycle; level: active now
  assign dif.edge_hit  = |(act & ~s_ff.act_prev);
  assign dif.level_hit = |act;

  // next state
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.act_prev = act;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_unsel_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dif.sel == '0) |-> !dif.edge_hit && !dif.level_hit)
    else $error("unselected pins produced a detection");

  a_pol_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    dif.sel[0] && (dif.pins[0] == dif.pol[0]) |-> dif.level_hit)
    else $error("pin 0 at active level not seen");

endmodule

/* pbp_port_ctl.sv */
// port b pad control registers and pin interrupt logic behind apb
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "pbp_params.svh"

module pbp_port_ctl (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`PBP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`PBP_PINS-1:0]   pin_level,
  output logic      [`PBP_PINS-1:0]   pad_drv_n,
  output logic      [`PBP_PINS-1:0]   pad_pull_en,
  output logic      [`PBP_PINS-1:0]   pad_pull_dn,
  output logic      [`PBP_PINS-1:0]   pad_slew,
  output logic      [`PBP_PINS-1:0]   pad_drive_hi,
  output logic                        port_irq,
  output logic                        irq
);

  pbp_pkg::pbp_top_st_t  s_ff;
  pbp_pkg::pbp_top_st_t  nxt_s;
  pbp_det_if             dif ();
  logic                  setup;
  logic                  acc;
  logic                  wr;
  logic                  hit;
  logic                  ack;
  logic                  det_set;
  logic [31:0]           rdata;
  logic [`PBP_PINS-1:0]  sel_wide;
  logic [`PBP_PINS-1:0]  pol_wide;

  // -----------------------------------------------------------------
  // pin detector
  // -----------------------------------------------------------------
  assign dif.sel  = s_ff.sel;
  assign dif.pol  = s_ff.pol;
  assign dif.pins = pin_level[`PBP_IRQ_PINS-1:0];

  pbp_pin_detect u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .dif     (dif)
  );

  // -----------------------------------------------------------------
  // bus phase decode
  // -----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign acc   = psel & penable & s_ff.pready;
  assign wr    = acc & pwrite;

  // select and polarity widened to the port for the pull-down check
  assign sel_wide = {{(`PBP_PINS-`PBP_IRQ_PINS){1'b0}}, s_ff.sel};
  assign pol_wide = {{(`PBP_PINS-`PBP_IRQ_PINS){1'b0}}, s_ff.pol};

  // mode picks whether a held level sets the flag again
  assign det_set = dif.edge_hit | (s_ff.mode & dif.level_hit);

  // -----------------------------------------------------------------
  // read mux, upper bits stay zero
  // -----------------------------------------------------------------
  always_comb begin
    rdata = 32'h0;
    hit   = 1'b1;
    case (paddr)
      `PBP_OFF_DIR:      rdata[`PBP_PINS-1:0] = s_ff.dir;
      `PBP_OFF_PULL:     rdata[`PBP_PINS-1:0] = s_ff.pull;
      `PBP_OFF_SLEW:     rdata[`PBP_PINS-1:0] = s_ff.slew;
      `PBP_OFF_DRIVE:    rdata[`PBP_PINS-1:0] = s_ff.drive;
      `PBP_OFF_SC: begin
        rdata[`PBP_SC_MODE] = s_ff.mode;
        rdata[`PBP_SC_IE]   = s_ff.ie;
        rdata[`PBP_SC_FLAG] = s_ff.flag; // ack bit stays zero
      end
      `PBP_OFF_PSEL:     rdata[`PBP_IRQ_PINS-1:0] = s_ff.sel;
      `PBP_OFF_POL:      rdata[`PBP_IRQ_PINS-1:0] = s_ff.pol;
      `PBP_OFF_EVT_ST:   rdata[`PBP_EVT_W-1:0] = s_ff.evt_st;
      `PBP_OFF_EVT_MASK: rdata[`PBP_EVT_W-1:0] = s_ff.evt_mask;
      default:           hit = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    ack   = 1'b0;

    // register writes take effect at the access edge
    if (wr) begin
      case (paddr)
        `PBP_OFF_DIR:   nxt_s.dir   = pwdata[`PBP_PINS-1:0];
        `PBP_OFF_PULL:  nxt_s.pull  = pwdata[`PBP_PINS-1:0];
        `PBP_OFF_SLEW:  nxt_s.slew  = pwdata[`PBP_PINS-1:0];
        `PBP_OFF_DRIVE: nxt_s.drive = pwdata[`PBP_PINS-1:0];
        `PBP_OFF_SC: begin
          nxt_s.mode = pwdata[`PBP_SC_MODE];
          nxt_s.ie   = pwdata[`PBP_SC_IE];
          ack        = pwdata[`PBP_SC_ACK];
        end
        `PBP_OFF_PSEL:  nxt_s.sel = pwdata[`PBP_IRQ_PINS-1:0];
        `PBP_OFF_POL:   nxt_s.pol = pwdata[`PBP_IRQ_PINS-1:0];
        `PBP_OFF_EVT_ST:
          nxt_s.evt_st = s_ff.evt_st & ~pwdata[`PBP_EVT_W-1:0];
        `PBP_OFF_EVT_MASK:
          nxt_s.evt_mask = pwdata[`PBP_EVT_W-1:0];
        default: ;
      endcase
    end

    // flag: hardware set wins over acknowledge, writes never set it
    nxt_s.flag = det_set | (s_ff.flag & ~ack);

    // sticky events, a new event beats the write-one clear
    if (det_set) begin
      nxt_s.evt_st[`PBP_EVT_DET] = 1'b1;
    end
    if (ack && det_set) begin
      nxt_s.evt_st[`PBP_EVT_HELD] = 1'b1;
    end

    // pad controls follow the register values of the next cycle
    nxt_s.pad_drv_n   = ~nxt_s.dir;
    nxt_s.pad_pull_en = nxt_s.pull & ~nxt_s.dir;
    nxt_s.pad_pull_dn = nxt_s.pull & ~nxt_s.dir
                      & {{(`PBP_PINS-`PBP_IRQ_PINS){1'b0}},
                         nxt_s.sel & nxt_s.pol};
    nxt_s.pad_slew     = nxt_s.slew & nxt_s.dir;
    nxt_s.pad_drive_hi = nxt_s.drive & nxt_s.dir;

    // interrupt outputs
    nxt_s.port_irq = nxt_s.flag & nxt_s.ie;
    nxt_s.irq      = |(nxt_s.evt_st & nxt_s.evt_mask);

    // bus answer: one wait-free access phase after every setup
    nxt_s.pready  = setup;
    nxt_s.pslverr = setup & ~hit;
    nxt_s.prdata  = (setup && !pwrite) ? rdata : 32'h0;
  end

  // -----------------------------------------------------------------
  // state register, everything but pad_drv_n clears on reset
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff           <= '0;
      s_ff.pad_drv_n <= '1; // drivers off, pins float as inputs
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign prdata       = s_ff.prdata;
  assign pready       = s_ff.pready;
  assign pslverr      = s_ff.pslverr;
  assign pad_drv_n    = s_ff.pad_drv_n;
  assign pad_pull_en  = s_ff.pad_pull_en;
  assign pad_pull_dn  = s_ff.pad_pull_dn;
  assign pad_slew     = s_ff.pad_slew;
  assign pad_drive_hi = s_ff.pad_drive_hi;
  assign port_irq     = s_ff.port_irq;
  assign irq          = s_ff.irq;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pull_follows_bit: assert property (
    pad_pull_en == (s_ff.pull & ~s_ff.dir))
    else $error("pull enable does not follow pull bits");

  a_no_pull_out: assert property (
    (pad_pull_en & ~pad_drv_n) == '0)
    else $error("pull active on a driven pin");

  a_pull_down_gate: assert property (
    (pad_pull_dn & ~(sel_wide & pol_wide)) == '0)
    else $error("pull-down without rising interrupt select");

  a_slew_input_off: assert property (
    (pad_slew & pad_drv_n) == '0)
    else $error("slew control active on an input");

  a_drive_input_low: assert property (
    (pad_drive_hi & pad_drv_n) == '0)
    else $error("high drive on an input");

  a_flag_write_none: assert property (
    wr && paddr == `PBP_OFF_SC && pwdata[`PBP_SC_FLAG] && !s_ff.flag
      && !det_set |=> !s_ff.flag)
    else $error("software write set the flag");

  a_flag_sets: assert property (
    det_set |=> s_ff.flag ##1 (s_ff.flag || $past(ack)))
    else $error("detection did not set the flag");

  a_ack_clears: assert property (
    ack && !det_set |=> !s_ff.flag)
    else $error("acknowledge did not clear the flag");

  a_ack_reads_zero: assert property (
    setup && !pwrite && paddr == `PBP_OFF_SC |=> !prdata[`PBP_SC_ACK])
    else $error("acknowledge bit read back as one");

  a_req_needs_en: assert property (
    port_irq == (s_ff.flag && s_ff.ie))
    else $error("port request does not match flag and enable");

  a_edge_only: assert property (
    !s_ff.mode && !dif.edge_hit && ack |=> !s_ff.flag)
    else $error("level set the flag in edge-only mode");

  a_level_hold: assert property (
    s_ff.mode && dif.level_hit |=> s_ff.flag [*1] ##0 port_irq == s_ff.ie)
    else $error("flag not held by an active level");

  a_upper_zero: assert property (
    setup && !pwrite && (paddr == `PBP_OFF_PSEL || paddr == `PBP_OFF_POL)
      |=> prdata[31:`PBP_IRQ_PINS] == '0)
    else $error("upper bits read non-zero");

  a_drive_dir: assert property (
    wr && paddr == `PBP_OFF_DIR |=> pad_drv_n == ~$past(pwdata[7:0]))
    else $error("driver enable does not follow direction");

  a_pull_write: assert property (
    wr && paddr == `PBP_OFF_PULL
      |=> pad_pull_en == ($past(pwdata[`PBP_PINS-1:0]) & ~s_ff.dir))
    else $error("pull write did not reach the pads");

  a_dn_on_driven: assert property (
    (pad_pull_dn & ~pad_drv_n) == '0)
    else $error("pull-down active on a driven pin");

  a_dn_needs_pull: assert property (
    (pad_pull_dn & ~pad_pull_en) == '0)
    else $error("pull-down without an enabled pull device");

  a_dn_upper_zero: assert property (
    pad_pull_dn[`PBP_PINS-1:`PBP_IRQ_PINS] == '0)
    else $error("pull-down on a pin without interrupt input");

  a_slew_write: assert property (
    wr && paddr == `PBP_OFF_SLEW
      |=> pad_slew == ($past(pwdata[`PBP_PINS-1:0]) & ~pad_drv_n))
    else $error("slew write did not reach the output pins");

  a_drive_write: assert property (
    wr && paddr == `PBP_OFF_DRIVE
      |=> pad_drive_hi == ($past(pwdata[`PBP_PINS-1:0]) & ~pad_drv_n))
    else $error("drive write did not reach the output pins");

  a_flag_only_det: assert property (
    !s_ff.flag && !det_set |=> !s_ff.flag)
    else $error("flag rose without a detection");

  a_flag_sticky: assert property (
    s_ff.flag && !ack |=> s_ff.flag)
    else $error("flag fell without an acknowledge");

  a_ack_set_wins: assert property (
    ack && det_set |=> s_ff.flag)
    else $error("acknowledge beat a detection in the same cycle");

  a_req_off_dis: assert property (
    !s_ff.ie |-> !port_irq)
    else $error("port request while interrupts disabled");

  a_edge_no_level: assert property (
    !s_ff.mode && !dif.edge_hit && !s_ff.flag |=> !s_ff.flag)
    else $error("held level set the flag in edge-only mode");

  a_held_event: assert property (
    ack && det_set |=> s_ff.evt_st[`PBP_EVT_HELD])
    else $error("acknowledge during detection not recorded");

  a_sc_upper_zero: assert property (
    setup && !pwrite && paddr == `PBP_OFF_SC
      |=> prdata[31:`PBP_SC_FLAG+1] == '0)
    else $error("status and control upper bits read non-zero");

endmodule

/* pbp_pin_board.sv */
// board model: external drivers, pull resistors and floating pins
`timescale 1ns/1ps
`include "pbp_params.svh"

module pbp_pin_board (
  input  wire logic                 pclk,
  input  wire logic [`PBP_PINS-1:0] pad_pull_en,
  input  wire logic [`PBP_PINS-1:0] pad_pull_dn,
  input  wire logic [`PBP_PINS-1:0] ext_en,
  input  wire logic [`PBP_PINS-1:0] ext_val,
  output logic      [`PBP_PINS-1:0] pin_level
);
  initial pin_level = '1;

  // -----------------------------------------------------------------
  // pin level, registered so it reaches the block synchronous to pclk
  // -----------------------------------------------------------------
  // an external driver wins, then the pull device; a floating pin
  // toggles every cycle so no settled value can pass for a real one
  always @(posedge pclk) begin
    for (int i = 0; i < `PBP_PINS; i++) begin
      if (ext_en[i])
        pin_level[i] <= ext_val[i];
      else if (pad_pull_en[i])
        pin_level[i] <= ~pad_pull_dn[i];
      else
        pin_level[i] <= ~pin_level[i];
    end
  end
endmodule

/* port_b_pad_ctl_and_pin_irq_test.sv */
// self-checking bench of the port b pad control and pin interrupt block
`timescale 1ns/1ps
`include "pbp_params.svh"

module port_b_pad_ctl_and_pin_irq_test;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`PBP_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [`PBP_PINS-1:0]   pin_level;
  logic [`PBP_PINS-1:0]   pad_drv_n;
  logic [`PBP_PINS-1:0]   pad_pull_en;
  logic [`PBP_PINS-1:0]   pad_pull_dn;
  logic [`PBP_PINS-1:0]   pad_slew;
  logic [`PBP_PINS-1:0]   pad_drive_hi;
  logic                   port_irq;
  logic                   irq;
  logic [`PBP_PINS-1:0]   ext_en;
  logic [`PBP_PINS-1:0]   ext_val;
  logic [31:0]            rdata;
  logic                   serr;
  int                     error_cnt;
  int                     cmp_count;

  pbp_port_ctl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_level(pin_level),
    .pad_drv_n(pad_drv_n), .pad_pull_en(pad_pull_en),
    .pad_pull_dn(pad_pull_dn), .pad_slew(pad_slew),
    .pad_drive_hi(pad_drive_hi), .port_irq(port_irq), .irq(irq));

  pbp_pin_board board_u (
    .pclk(pclk), .pad_pull_en(pad_pull_en), .pad_pull_dn(pad_pull_dn),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

  // -----------------------------------------------------------------
  // clock and shared tasks
  // -----------------------------------------------------------------
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives in this step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk("prdata", rdata, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // -----------------------------------------------------------------
  // watchdog
  // -----------------------------------------------------------------
  initial begin
    tick(5000);
    error_cnt++;
    summarize();
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    ext_en = 8'h0f;
    ext_val = 8'h0f;
    error_cnt = 0;
    cmp_count = 0;
    tick(4);
    presetn <= 1'b1;
    tick(1);
    chk("drv_n", 32'(pad_drv_n), 32'hff);
    chk("pull_en", 32'(pad_pull_en), 32'h0);
    chk("pready", 32'(pready), 32'h0);
    for (int i = 0; i < 9; i++) rd(12'(4 * i), 32'h0);
    wr(12'h024, 32'hff);
    chk("pslverr", 32'(serr), 32'h1);
    rd(12'h024, 32'h0);
    // register widths and the self-clearing bits
    wr(`PBP_OFF_SC, 32'hff);
    rd(`PBP_OFF_SC, 32'h03);
    wr(`PBP_OFF_PSEL, 32'hff);
    rd(`PBP_OFF_PSEL, 32'h0f);
    wr(`PBP_OFF_POL, 32'hff);
    rd(`PBP_OFF_POL, 32'h0f);
    wr(`PBP_OFF_SC, 32'h0);
    // pad controls with half the port as outputs
    wr(`PBP_OFF_DIR, 32'h0f);
    wr(`PBP_OFF_PULL, 32'hff);
    wr(`PBP_OFF_SLEW, 32'hff);
    wr(`PBP_OFF_DRIVE, 32'hff);
    tick(1);
    chk("drv_n", 32'(pad_drv_n), 32'hf0);
    chk("pull_en", 32'(pad_pull_en), 32'hf0);
    chk("pull_dn", 32'(pad_pull_dn), 32'h0);
    chk("slew", 32'(pad_slew), 32'h0f);
    chk("drive", 32'(pad_drive_hi), 32'h0f);
    rd(`PBP_OFF_SLEW, 32'hff);
    wr(`PBP_OFF_DIR, 32'h0);
    tick(1);
    chk("pull_en", 32'(pad_pull_en), 32'hff);
    chk("pull_dn", 32'(pad_pull_dn), 32'h0f);
    chk("slew", 32'(pad_slew), 32'h0);
    chk("drive", 32'(pad_drive_hi), 32'h0);
    wr(`PBP_OFF_POL, 32'h05);
    wr(`PBP_OFF_PSEL, 32'h03);
    tick(1);
    chk("pull_dn", 32'(pad_pull_dn), 32'h01);
    wr(`PBP_OFF_PULL, 32'h0);
    tick(1);
    chk("pull_en", 32'(pad_pull_en), 32'h0);
    // falling edge on pin 0, edge-only mode
    wr(`PBP_OFF_POL, 32'h0);
    wr(`PBP_OFF_PSEL, 32'h01);
    wr(`PBP_OFF_EVT_ST, 32'h3);
    wr(`PBP_OFF_SC, 32'h06);
    rd(`PBP_OFF_SC, 32'h02);
    ext_val <= 8'h0e;
    tick(4);
    rd(`PBP_OFF_SC, 32'h0a);
    chk("port_irq", 32'(port_irq), 32'h1);
    wr(`PBP_OFF_SC, 32'h06);
    rd(`PBP_OFF_SC, 32'h02);
    chk("port_irq", 32'(port_irq), 32'h0);
    ext_val <= 8'h0c;
    tick(4);
    rd(`PBP_OFF_SC, 32'h02);
    ext_val <= 8'h0f;
    tick(4);
    wr(`PBP_OFF_SC, 32'h0);
    ext_val <= 8'h0e;
    tick(4);
    rd(`PBP_OFF_SC, 32'h08);
    chk("port_irq", 32'(port_irq), 32'h0);
    // level mode keeps the flag while pin 0 stays low
    wr(`PBP_OFF_SC, 32'h07);
    rd(`PBP_OFF_SC, 32'h0b);
    chk("port_irq", 32'(port_irq), 32'h1);
    // acknowledge while the level stays: detection wins, held event seen
    wr(`PBP_OFF_SC, 32'h07);
    rd(`PBP_OFF_SC, 32'h0b);
    rd(`PBP_OFF_EVT_ST, 32'h3);
    ext_val <= 8'h0f;
    tick(4);
    wr(`PBP_OFF_SC, 32'h07);
    rd(`PBP_OFF_SC, 32'h03);
    // rising edge with polarity one, then the event interrupt
    wr(`PBP_OFF_SC, 32'h06);
    ext_val <= 8'h0e;
    tick(4);
    wr(`PBP_OFF_POL, 32'h01);
    wr(`PBP_OFF_SC, 32'h06);
    wr(`PBP_OFF_EVT_ST, 32'h3);
    wr(`PBP_OFF_EVT_MASK, 32'h1);
    rd(`PBP_OFF_EVT_ST, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    ext_val <= 8'h0f;
    tick(4);
    rd(`PBP_OFF_SC, 32'h0a);
    rd(`PBP_OFF_EVT_ST, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(`PBP_OFF_EVT_MASK, 32'h0);
    tick(1);
    chk("irq", 32'(irq), 32'h0);
    wr(`PBP_OFF_EVT_MASK, 32'h1);
    wr(`PBP_OFF_EVT_ST, 32'h1);
    tick(1);
    chk("irq", 32'(irq), 32'h0);
    rd(`PBP_OFF_EVT_ST, 32'h0);
    summarize();
  end
endmodule
